// *** tvd_pkg.sv ***
// Package for the trap vector dispatch block: offsets, fields, reset values and codes
package tvd_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	// Register byte offsets
	localparam logic [7:0]  OFS_CFG       = 8'h00;
	localparam logic [7:0]  OFS_VSEG      = 8'h04;
	localparam logic [7:0]  OFS_TFLAG     = 8'h08;
	localparam logic [7:0]  OFS_ISTAT     = 8'h0c;
	localparam logic [7:0]  OFS_IMASK     = 8'h10;
	localparam logic [7:0]  OFS_STATE     = 8'h14;
	// Config field: vector spacing, 0 gives 4 bytes
	localparam int          VSC_LSB       = 0;
	localparam int          VSC_W         = 2;
	localparam logic [1:0]  VSC_RST       = 2'h0;
	localparam logic [7:0]  VSEG_RST      = 8'h00;
	// Trap flag bit positions
	localparam int          TF_URGENT     = 15;
	localparam int          TF_STK_OVER   = 14;
	localparam int          TF_STK_UNDER  = 13;
	localparam int          TF_SBRK       = 12;
	localparam int          TF_UNDEF      = 7;
	localparam int          TF_PMERR      = 6;
	localparam int          TF_PROT       = 1;
	localparam int          TF_ILLW       = 0;
	// Interrupt status bits
	localparam int          IS_CLASS_A    = 0;
	localparam int          IS_CLASS_B    = 1;
	localparam int          IS_DEFER      = 2;
	localparam int          IS_W          = 3;
	// Trap numbers
	localparam logic [6:0]  TN_RESET      = 7'h00;
	localparam logic [6:0]  TN_URGENT     = 7'h02;
	localparam logic [6:0]  TN_STK_OVER   = 7'h04;
	localparam logic [6:0]  TN_STK_UNDER  = 7'h06;
	localparam logic [6:0]  TN_SBRK       = 7'h08;
	localparam logic [6:0]  TN_CLASS_B    = 7'h0a;
	// Service priority levels
	localparam logic [1:0]  LVL_NONE      = 2'h0;
	localparam logic [1:0]  LVL_B         = 2'h1;
	localparam logic [1:0]  LVL_A         = 2'h2;
	typedef enum logic [1:0] {TVD_SRC_NONE, TVD_SRC_RESET, TVD_SRC_TRAP, TVD_SRC_IRQ} tvd_src_t;
endpackage

// *** tvd_sticky.sv ***
// Sticky flag cells: set wins over clear
`timescale 1ns/1ps
`default_nettype none
module tvd_sticky #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] q_d;

	always_comb
	begin
		q_d = set_i | (q_o & ~clr_i);
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			q_o <= '0;
		else
			q_o <= q_d;
	end
endmodule // tvd_sticky
`default_nettype wire

// *** tvd_trap_dispatch.sv ***
// Trap and vector dispatch with Wishbone register slave
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
module tvd_trap_dispatch #(
	parameter bit HAS_SECOND_ASC = 1'b0
) (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic        RESET_REQ_I,
	input  wire logic        URGENT_IRQ_I,
	input  wire logic        STACK_OVER_I,
	input  wire logic        STACK_UNDER_I,
	input  wire logic        SOFT_BREAK_I,
	input  wire logic        UNDEF_OPC_I,
	input  wire logic        PMEM_ERR_I,
	input  wire logic        PROT_FAULT_I,
	input  wire logic        ILL_WORD_I,
	input  wire logic        SW_TRAP_I,
	input  wire logic [6:0]  SW_TRAP_NUM_I,
	input  wire logic        IRQ_REQ_I,
	input  wire logic [6:0]  IRQ_NUM_I,
	input  wire logic        TRAP_DONE_I,
	output logic             BRANCH_O,
	output logic [23:0]      VEC_ADDR_O,
	output logic [6:0]       TRAP_NUM_O,
	output logic             IRQ_ACK_O,
	output logic             IRQ_BLOCK_O,
	output logic             INT_O
);
	logic [7:0]  pend_q, pend_d, ev;
	logic [1:0]  lvl_q, lvl_d, lvl_base;
	logic        boot_q;
	logic [1:0]  vsc_q, vsc_d;
	logic [7:0]  vseg_q, vseg_d;
	logic [2:0]  imask_q, imask_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic        br_q, br_d, iack_q, iack_d, blk_q, blk_d, int_q, int_d;
	logic [23:0] vec_q, vec_d;
	logic [6:0]  num_q, num_d;
	logic [15:0] tf_q, tf_set, tf_clr;
	logic [2:0]  is_q, is_set, is_clr;
	logic [7:0]  take;
	logic [6:0]  num_sel;
	tvd_pkg::tvd_src_t src;
	logic        req, wr, rd, a_pend, b_pend, a_go, b_go, irq_ok;

	// Nodes without a source; second serial channel nodes when absent
	function automatic logic node_assigned(input logic [6:0] n);
		logic r;
		r = 1'b1;
		if (n inside {7'h28, 7'h29, 7'h3f, 7'h40, 7'h41, 7'h4b} || (n >= 7'h54 && n <= 7'h5d))
			r = 1'b0;
		if (!HAS_SECOND_ASC && n inside {7'h42, 7'h48, 7'h49, 7'h4a, 7'h5e})
			r = 1'b0;
		return r;
	endfunction

	assign req = WB_CYC_I && WB_STB_I && !ack_q;
	assign wr  = req && WB_WE_I;
	assign rd  = req && !WB_WE_I;
	assign ev  = {ILL_WORD_I, PROT_FAULT_I, PMEM_ERR_I, UNDEF_OPC_I,
		SOFT_BREAK_I, STACK_UNDER_I, STACK_OVER_I, URGENT_IRQ_I};

	// Trap flags, cleared by writing ones
	always_comb
	begin
		tf_set = '0;
		tf_set[tvd_pkg::TF_URGENT] = URGENT_IRQ_I;
		tf_set[tvd_pkg::TF_STK_OVER]  = STACK_OVER_I;
		tf_set[tvd_pkg::TF_STK_UNDER] = STACK_UNDER_I;
		tf_set[tvd_pkg::TF_SBRK]      = SOFT_BREAK_I;
		tf_set[tvd_pkg::TF_UNDEF]     = UNDEF_OPC_I;
		tf_set[tvd_pkg::TF_PMERR]  = PMEM_ERR_I;
		tf_set[tvd_pkg::TF_PROT]   = PROT_FAULT_I;
		tf_set[tvd_pkg::TF_ILLW]   = ILL_WORD_I;
		tf_clr = '0;
		if (wr && WB_ADR_I == tvd_pkg::OFS_TFLAG)
			tf_clr = WB_DAT_I[15:0] & {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	end

	tvd_sticky #(.W(16)) u_tflag (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.set_i   (tf_set),
		.clr_i   (tf_clr),
		.q_o     (tf_q)
	);

	// Dispatch: reset, class A, class B, software trap, standard request
	always_comb
	begin
		lvl_base = TRAP_DONE_I ? tvd_pkg::LVL_NONE : lvl_q;
		a_pend   = |pend_q[3:0];
		b_pend   = |pend_q[7:4];
		a_go     = a_pend && lvl_base < tvd_pkg::LVL_A;
		b_go     = b_pend && lvl_base < tvd_pkg::LVL_B;
		// Request still stands at its ack edge: never take it twice
		irq_ok   = IRQ_REQ_I && lvl_base == tvd_pkg::LVL_NONE && !a_pend && !b_pend
			&& !iack_q && node_assigned(IRQ_NUM_I);
		take     = '0;
		num_sel  = tvd_pkg::TN_RESET;
		lvl_d    = lvl_base;
		src      = tvd_pkg::TVD_SRC_NONE;
		if (boot_q || RESET_REQ_I)
		begin
			src     = tvd_pkg::TVD_SRC_RESET;
			take    = 8'hff;
			lvl_d   = tvd_pkg::LVL_NONE;
		end
		else if (a_go)
		begin
			src   = tvd_pkg::TVD_SRC_TRAP;
			lvl_d = tvd_pkg::LVL_A;
			if (pend_q[0])
			begin
				num_sel = tvd_pkg::TN_URGENT;
				take[0] = 1'b1;
			end
			else if (pend_q[1])
			begin
				num_sel = tvd_pkg::TN_STK_OVER;
				take[1] = 1'b1;
			end
			else if (pend_q[2])
			begin
				num_sel = tvd_pkg::TN_STK_UNDER;
				take[2] = 1'b1;
			end
			else
			begin
				num_sel = tvd_pkg::TN_SBRK;
				take[3] = 1'b1;
			end
		end
		else if (b_go)
		begin
			src     = tvd_pkg::TVD_SRC_TRAP;
			num_sel = tvd_pkg::TN_CLASS_B;
			take    = 8'hf0;
			lvl_d   = tvd_pkg::LVL_B;
		end
		else if (SW_TRAP_I)
		begin
			src     = tvd_pkg::TVD_SRC_TRAP;
			num_sel = SW_TRAP_NUM_I;
		end
		else if (irq_ok)
		begin
			src     = tvd_pkg::TVD_SRC_IRQ;
			num_sel = IRQ_NUM_I;
		end
		pend_d = (pend_q & ~take) | ev;
		br_d   = src != tvd_pkg::TVD_SRC_NONE;
		iack_d = src == tvd_pkg::TVD_SRC_IRQ;
		num_d  = br_d ? num_sel : num_q;
		vec_d  = br_d ? {vseg_q, 16'(({7'h00, num_sel, 2'b00}) << vsc_q)} : vec_q;
		blk_d  = lvl_d != tvd_pkg::LVL_NONE;
	end

	// Interrupt status: class A and class B trap entries and deferrals, cleared on read
	always_comb
	begin
		is_set = '0;
		is_set[tvd_pkg::IS_CLASS_A] = a_go && src == tvd_pkg::TVD_SRC_TRAP;
		is_set[tvd_pkg::IS_CLASS_B] = !a_go && b_go && src == tvd_pkg::TVD_SRC_TRAP;
		is_set[tvd_pkg::IS_DEFER]   = (a_pend && !a_go) || (b_pend && !b_go && !a_go);
		is_clr = (rd && WB_ADR_I == tvd_pkg::OFS_ISTAT) ? '1 : '0;
		int_d  = |((is_set | (is_q & ~is_clr)) & imask_q);
	end

	tvd_sticky #(.W(tvd_pkg::IS_W)) u_istat (
		.clk_i   (SYS_CLK_I),
		.rst_b_i (RST_B_I),
		.set_i   (is_set),
		.clr_i   (is_clr),
		.q_o     (is_q)
	);

	// Register bus
	always_comb
	begin
		vsc_d   = vsc_q;
		vseg_d  = vseg_q;
		imask_d = imask_q;
		ack_d   = req;
		rdat_d  = '0;
		if (wr && WB_SEL_I[0])
		begin
			unique case (WB_ADR_I)
				tvd_pkg::OFS_CFG:   vsc_d   = WB_DAT_I[tvd_pkg::VSC_LSB +: tvd_pkg::VSC_W];
				tvd_pkg::OFS_VSEG:  vseg_d  = WB_DAT_I[7:0];
				tvd_pkg::OFS_IMASK: imask_d = WB_DAT_I[tvd_pkg::IS_W-1:0];
				default:            vsc_d   = vsc_q;
			endcase
		end
		if (rd)
		begin
			unique case (WB_ADR_I)
				tvd_pkg::OFS_CFG:   rdat_d = {30'h0, vsc_q};
				tvd_pkg::OFS_VSEG:  rdat_d = {24'h0, vseg_q};
				tvd_pkg::OFS_TFLAG: rdat_d = {16'h0, tf_q};
				tvd_pkg::OFS_ISTAT: rdat_d = {29'h0, is_q};
				tvd_pkg::OFS_IMASK: rdat_d = {29'h0, imask_q};
				tvd_pkg::OFS_STATE: rdat_d = {21'h0, lvl_q, 1'b0, num_q, pend_q != 8'h00};
				default:            rdat_d = '0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			pend_q  <= '0;
			lvl_q   <= tvd_pkg::LVL_NONE;
			boot_q  <= 1'b1;
			vsc_q   <= tvd_pkg::VSC_RST;
			vseg_q  <= tvd_pkg::VSEG_RST;
			imask_q <= '0;
			ack_q   <= 1'b0;
			rdat_q  <= '0;
			br_q    <= 1'b0;
			iack_q  <= 1'b0;
			blk_q   <= 1'b0;
			int_q   <= 1'b0;
			vec_q   <= '0;
			num_q   <= '0;
		end
		else
		begin
			pend_q  <= pend_d;
			lvl_q   <= lvl_d;
			boot_q  <= 1'b0;
			vsc_q   <= vsc_d;
			vseg_q  <= vseg_d;
			imask_q <= imask_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
			br_q    <= br_d;
			iack_q  <= iack_d;
			blk_q   <= blk_d;
			int_q   <= int_d;
			vec_q   <= vec_d;
			num_q   <= num_d;
		end
	end

	assign WB_ACK_O    = ack_q;
	assign WB_DAT_O    = rdat_q;
	assign BRANCH_O    = br_q;
	assign VEC_ADDR_O  = vec_q;
	assign TRAP_NUM_O  = num_q;
	assign IRQ_ACK_O   = iack_q;
	assign IRQ_BLOCK_O = blk_q;
	assign INT_O       = int_q;

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);

	vec_spacing_a: assert property (BRANCH_O |-> VEC_ADDR_O[15:0] == 16'({7'h00, TRAP_NUM_O, 2'b00} << vsc_q)
		|| $past(vsc_q) != vsc_q) else $error("vector offset wrong");
	vec_segment_a: assert property (BRANCH_O && $stable(vseg_q) |-> VEC_ADDR_O[23:16] == vseg_q)
		else $error("vector segment wrong");
	trap_branch_a: assert property (URGENT_IRQ_I && !RESET_REQ_I && lvl_q != tvd_pkg::LVL_A && !TRAP_DONE_I
		|-> ##[1:3] BRANCH_O) else $error("urgent trap not taken");
	flag_set_a: assert property (STACK_OVER_I |=> tf_q[tvd_pkg::TF_STK_OVER])
		else $error("flag not set");
	defer_hold_a: assert property (lvl_q == tvd_pkg::LVL_A && !TRAP_DONE_I && !RESET_REQ_I
		|=> !(BRANCH_O && TRAP_NUM_O == tvd_pkg::TN_CLASS_B)) else $error("trap not deferred");
	irq_block_a: assert property (IRQ_BLOCK_O |-> !IRQ_ACK_O) else $error("request during trap");
	reset_vec_a: assert property (RESET_REQ_I |=> BRANCH_O && TRAP_NUM_O == tvd_pkg::TN_RESET && !IRQ_BLOCK_O)
		else $error("reset vector wrong");
	class_b_vec_a: assert property (!a_go && b_go && !boot_q && !RESET_REQ_I
		|=> TRAP_NUM_O == tvd_pkg::TN_CLASS_B) else $error("class b number wrong");
	sw_trap_a: assert property (SW_TRAP_I && !boot_q && !RESET_REQ_I && !a_go && !b_go
		|=> BRANCH_O && TRAP_NUM_O == $past(SW_TRAP_NUM_I) && lvl_q == $past(lvl_base))
		else $error("software trap wrong");
	asc_node_a: assert property (IRQ_ACK_O |-> node_assigned(TRAP_NUM_O)) else $error("unassigned node");
	a_over_b_a: assert property (a_go && b_pend && !boot_q && !RESET_REQ_I
		|=> TRAP_NUM_O != tvd_pkg::TN_CLASS_B ##1 pend_q[7:4] != 4'h0) else $error("class b first");
	cov_urgent: cover property (BRANCH_O && TRAP_NUM_O == tvd_pkg::TN_URGENT);
	cov_class_b: cover property (BRANCH_O && TRAP_NUM_O == tvd_pkg::TN_CLASS_B);
	cov_preempt: cover property (lvl_q == tvd_pkg::LVL_B ##1 lvl_q == tvd_pkg::LVL_A);
	cov_irq: cover property (IRQ_ACK_O);
endmodule // tvd_trap_dispatch
`default_nettype wire

// *** tvd_core_model.sv ***
// Core sequencer model: ends trap services and raises standard requests
`timescale 1ns/1ps
`default_nettype none
module tvd_core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       branch_i,
	input  wire logic       irq_ack_i,
	input  wire logic       irq_go_i,
	input  wire logic       irq_drop_i,
	input  wire logic [6:0] irq_num_i,
	input  wire logic [3:0] dly_i,
	input  wire logic       done_go_i,
	output logic            done_o,
	output logic            req_o,
	output logic      [6:0] num_o
);
	logic [3:0] cnt_q;
	// Service ends dly_i cycles after a branch; zero leaves it to the bench
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			{cnt_q, done_o, req_o, num_o} <= '0;
		else
		begin
			if (branch_i && dly_i != 4'h0)
				cnt_q <= dly_i;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			done_o <= done_go_i || cnt_q == 4'h1;
			// Request held until taken or dropped; number is inverted once released
			if (irq_go_i)
			begin
				req_o <= 1'b1;
				num_o <= irq_num_i;
			end
			else if (req_o && (irq_ack_i || irq_drop_i))
			begin
				req_o <= 1'b0;
				num_o <= ~num_o;
			end
		end
	end
endmodule // tvd_core_model
`default_nettype wire

// *** tvd_trap_dispatch_tb_top.sv ***
// Self-checking bench for the trap vector dispatch block
`timescale 1ns/1ps
`default_nettype none
module tvd_trap_dispatch_tb_top;
	logic SYS_CLK_I, RST_B_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, BRANCH_O, IRQ_ACK_O, IRQ_BLOCK_O, INT_O;
	logic RESET_REQ_I, URGENT_IRQ_I, STACK_OVER_I, STACK_UNDER_I, SOFT_BREAK_I, UNDEF_OPC_I, PMEM_ERR_I;
	logic PROT_FAULT_I, ILL_WORD_I, SW_TRAP_I, IRQ_REQ_I, TRAP_DONE_I, irq_go, irq_drop, done_go;
	logic [7:0]  WB_ADR_I;
	logic [3:0]  WB_SEL_I, dly;
	logic [31:0] WB_DAT_I, WB_DAT_O, rd;
	logic [23:0] VEC_ADDR_O;
	logic [6:0]  TRAP_NUM_O, IRQ_NUM_I, SW_TRAP_NUM_I, irq_num;
	logic [9:0]  ev;
	int          failures, samples_checked;
	localparam logic [7:0] SEG = 8'h12, TF = tvd_pkg::OFS_TFLAG, ST = tvd_pkg::OFS_ISTAT;
	localparam logic [6:0] NUM [8] = '{7'h02, 7'h04, 7'h06, 7'h08, 7'h0a, 7'h0a, 7'h0a, 7'h0a};
	localparam int         FB [8] = '{15, 14, 13, 12, 7, 6, 1, 0};
	assign {RESET_REQ_I, SW_TRAP_I, ILL_WORD_I, PROT_FAULT_I, PMEM_ERR_I, UNDEF_OPC_I, SOFT_BREAK_I,
		STACK_UNDER_I, STACK_OVER_I, URGENT_IRQ_I} = ev;
	tvd_trap_dispatch dut (.SYS_CLK_I, .RST_B_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
		.WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .RESET_REQ_I, .URGENT_IRQ_I, .STACK_OVER_I, .STACK_UNDER_I,
		.SOFT_BREAK_I, .UNDEF_OPC_I, .PMEM_ERR_I, .PROT_FAULT_I, .ILL_WORD_I, .SW_TRAP_I, .SW_TRAP_NUM_I,
		.IRQ_REQ_I, .IRQ_NUM_I, .TRAP_DONE_I, .BRANCH_O, .VEC_ADDR_O, .TRAP_NUM_O, .IRQ_ACK_O,
		.IRQ_BLOCK_O, .INT_O);
	tvd_core_model core (.clk_i(SYS_CLK_I), .rst_b_i(RST_B_I), .branch_i(BRANCH_O), .irq_ack_i(IRQ_ACK_O),
		.irq_go_i(irq_go), .irq_drop_i(irq_drop), .irq_num_i(irq_num), .dly_i(dly), .done_go_i(done_go),
		.done_o(TRAP_DONE_I), .req_o(IRQ_REQ_I), .num_o(IRQ_NUM_I));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, we, a, d};
		do
		begin
			@(posedge SYS_CLK_I);
			n++;
		end
		while (WB_ACK_O !== 1'b1 && n < 40);
		rd = WB_DAT_O;
		{WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'h0;
		chk("ack", n, 2);
		@(posedge SYS_CLK_I);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk("read", rd, exp);
	endtask
	// Pulses launched at least one edge after any earlier task's last drive
	task automatic kick(input logic [9:0] e, input logic [2:0] c);
		@(posedge SYS_CLK_I);
		ev <= e;
		{irq_go, done_go, irq_drop} <= c;
	endtask
	task automatic br(input int c, input logic [6:0] num, input logic [23:0] v, input logic blk);
		int n;
		n = 0;
		do
		begin
			@(posedge SYS_CLK_I);
			{ev, irq_go, done_go, irq_drop} <= '0;
			n++;
		end
		while (BRANCH_O !== 1'b1 && n < 40);
		if (c != 0)
			chk("latency", n, c);
		chk("number", TRAP_NUM_O, num);
		chk("vector", VEC_ADDR_O, v);
		chk("block", IRQ_BLOCK_O, blk);
	endtask
	task automatic trap(input logic [9:0] e, input int c, input logic [6:0] num, input logic [15:0] o,
		input logic blk);
		kick(e, 3'h0);
		br(c, num, {SEG, o}, blk);
	endtask
	task automatic quiet(input int n);
		int k;
		k = 0;
		repeat (n)
		begin
			@(posedge SYS_CLK_I);
			{ev, irq_go, done_go, irq_drop} <= '0;
			k += int'(BRANCH_O !== 1'b0 || IRQ_ACK_O !== 1'b0);
		end
		chk("idle", k, 0);
	endtask
	initial
	begin
		SYS_CLK_I = 1'b0;
		forever #2.5 SYS_CLK_I = ~SYS_CLK_I;
	end
	initial
	begin
		#50000;
		failures++;
		stop_test();
	end
	initial
	begin
		RST_B_I = 1'b0;
		{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = '0;
		WB_SEL_I = 4'hf;
		{ev, irq_go, irq_drop, done_go, irq_num, SW_TRAP_NUM_I} = '0;
		dly = 4'h2;
		failures = 0;
		samples_checked = 0;
		repeat (4) @(posedge SYS_CLK_I);
		RST_B_I <= 1'b1;
		br(2, 7'h00, 24'h0, 1'b0);
		rdchk(tvd_pkg::OFS_CFG, 32'h0);
		rdchk(tvd_pkg::OFS_VSEG, 32'h0);
		rdchk(8'h1c, 32'h0);
		wb(1'b1, tvd_pkg::OFS_VSEG, {24'h0, SEG});
		$display("test reset and registers done");
		for (int i = 0; i < 8; i++)
		begin
			trap(10'h1 << i, 3, NUM[i], {7'h0, NUM[i], 2'h0}, 1'b1);
			rdchk(TF, 32'h1 << FB[i]);
			rdchk(TF, 32'h1 << FB[i]);
			wb(1'b1, TF, 32'h1 << FB[i]);
			rdchk(TF, 32'h0);
		end
		wb(1'b1, tvd_pkg::OFS_IMASK, 32'h1);
		chk("irq line", INT_O, 1'b1);
		rdchk(tvd_pkg::OFS_IMASK, 32'h1);
		rdchk(ST, 32'h3);
		@(posedge SYS_CLK_I);
		chk("irq line", INT_O, 1'b0);
		trap(10'h10, 3, 7'h0a, 16'h0028, 1'b1);
		repeat (2) @(posedge SYS_CLK_I);
		chk("masked irq", INT_O, 1'b0);
		$display("test flags and interrupt done");
		trap(10'h12, 3, 7'h04, 16'h0010, 1'b1);
		br(0, 7'h0a, {SEG, 16'h0028}, 1'b1);
		rdchk(ST, 32'h7);
		dly <= 4'h0;
		trap(10'h1, 3, 7'h02, 16'h0008, 1'b1);
		irq_num <= 7'h20;
		kick(10'h12, 3'h4);
		quiet(10);
		rdchk(tvd_pkg::OFS_STATE, 32'h405);
		kick(10'h0, 3'h2);
		br(0, 7'h04, {SEG, 16'h0010}, 1'b1);
		kick(10'h0, 3'h2);
		br(0, 7'h0a, {SEG, 16'h0028}, 1'b1);
		quiet(6);
		kick(10'h0, 3'h2);
		br(0, 7'h20, {SEG, 16'h0080}, 1'b0);
		chk("irq ack", IRQ_ACK_O, 1'b1);
		irq_num <= 7'h48;
		kick(10'h0, 3'h4);
		quiet(10);
		kick(10'h0, 3'h1);
		$display("test priority and deferral done");
		dly <= 4'h2;
		SW_TRAP_NUM_I <= 7'h7f;
		trap(10'h100, 2, 7'h7f, 16'h01fc, 1'b0);
		wb(1'b1, tvd_pkg::OFS_CFG, 32'h1);
		trap(10'h100, 2, 7'h7f, 16'h03f8, 1'b0);
		wb(1'b1, TF, 32'hffff);
		trap(10'h200, 2, 7'h00, 16'h0000, 1'b0);
		rdchk(TF, 32'h0);
		$display("test software trap and reset done");
		stop_test();
	end
endmodule // tvd_trap_dispatch_tb_top
`default_nettype wire
